// ### nvsc_dev_model.sv
// behavioural shadow-backed memory seen on the host bus
`timescale 1ns/10ps
`default_nettype none
`include "nvsc_map.svh"
module nvsc_dev_model #(
  parameter int BUSY_CLKS = 15
) (
  input wire logic core_clk,
  input wire logic supply_good,
  input wire nvsc_pkg::nvsc_bus_type bus,
  input wire logic [7:0] host_out,
  input wire logic host_oe_n,
  output logic [7:0] line
);
  localparam logic [13:0] KEYS [5] = '{`NVSC_KEY0, `NVSC_KEY1, `NVSC_KEY2, `NVSC_KEY3, `NVSC_KEY4};
  logic [7:0] mem [32768];
  logic [7:0] shadow [32768];
  logic [7:0] last_val = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [14:0] waddr = 15'h0000;
  logic [13:0] raddr = 14'h0000;
  logic was_wr = 1'b0;
  logic was_rd = 1'b0;
  logic sup_d = 1'b0;
  int step = 0;
  int busy = 0;
  wire rd_now = !bus.chip_select_n && bus.write_strobe_n;
  wire wr_now = !bus.chip_select_n && !bus.write_strobe_n;
  // drive only in a read, follows address
  wire drv = rd_now && !bus.output_enable_n && busy == 0;
  // released lines show the inverse, not a stale copy
  assign line = !host_oe_n ? host_out : drv ? mem[bus.byte_address] : ~last_val;
  initial begin
    for (int i = 0; i < 32768; i++) shadow[i] = 8'h00;
  end
  task automatic recall;
    for (int i = 0; i < 32768; i++) mem[i] = 8'h00;
    for (int i = 0; i < 32768; i++) mem[i] = shadow[i];
    busy = BUSY_CLKS;
  endtask
  task automatic key(input logic [13:0] a);
    // erase then program, blocked at low supply
    if (step == 5 && a == `NVSC_KEY_STORE && supply_good) begin
      for (int i = 0; i < 32768; i++) shadow[i] = 8'hff;
      for (int i = 0; i < 32768; i++) shadow[i] = mem[i];
      busy = BUSY_CLKS;
      step = 0;
    end else if (step == 5 && a == `NVSC_KEY_RECALL) begin
      recall();
      step = 0;
    end else if (step < 5 && a == KEYS[step]) begin
      step++;
    // mismatch restarts, may be a first key
    end else begin
      step = (a == `NVSC_KEY0) ? 1 : 0;
    end
  endtask
  always @(negedge core_clk) begin
    if (!host_oe_n || drv) last_val = line;
    // latched recall runs on supply rise
    if (supply_good && !sup_d) recall();
    sup_d = supply_good;
    if (busy > 0) begin
      busy = busy - 1;
      was_wr = 1'b0;
      was_rd = 1'b0;
    end else begin
      // byte lands as write ends; write aborts keys
      if (was_wr && !wr_now) begin
        mem[waddr] = wdata;
        step = 0;
      end
      if (wr_now) begin
        wdata = line;
        waddr = bus.byte_address;
      end
      if (was_rd && bus.chip_select_n) key(raddr);
      if (rd_now) raddr = bus.byte_address[13:0];
      was_wr = wr_now;
      was_rd = rd_now;
    end
  end
endmodule
`default_nettype wire

// ### nvsc_host.sv
// host bus controller driving the shadow-backed static memory
`timescale 1ns/10ps
`default_nettype none
`include "nvsc_map.svh"
// Operation
// - address stable from before write until strobe rises
// - host keeps output enable high through every write
// - store key: six reads 0e38 31c7 03e0 3c1f 303f 0fc0
// - recall key: same five keys, then 0c63
// - each key is its own select-framed read
// - key accesses are reads; output enable held high
// - select and strobe inactive until power-up recall ends
// - write strobe high throughout all key accesses
module nvsc_host #(
  parameter int STORE_CLKS = `NVSC_STORE_CLKS,
  parameter int RECALL_CLKS = `NVSC_RECALL_CLKS,
  parameter int RESTORE_CLKS = `NVSC_RESTORE_CLKS
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire nvsc_pkg::nvsc_req_type req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic store_refused,
  input wire logic supply_good,
  output nvsc_pkg::nvsc_bus_type bus,
  input wire logic [7:0] shared_data_lines_in,
  output logic [7:0] shared_data_lines_out,
  output logic shared_data_lines_oe_n
);
  typedef enum logic [5:0] {
    st_power = 6'h01,
    st_idle = 6'h02,
    st_access = 6'h04,
    st_gap = 6'h08,
    st_busy = 6'h10,
    st_key = 6'h20
  } nvsc_state_type;

  localparam int CW = 24;
  localparam logic [CW-1:0] ACCESS_CNT = CW'(`NVSC_CYCLE_CLKS);

  nvsc_state_type state;
  nvsc_pkg::nvsc_cmd_type cmd;
  logic [2:0] key_index;
  logic supply_seen;
  logic wait_load;
  logic [CW-1:0] wait_count;
  logic wait_done;
  logic [13:0] key_addr;

  nvsc_wait #(.WIDTH(CW)) timer (
    .core_clk(core_clk),
    .reset(reset),
    .load(wait_load),
    .count(wait_count),
    .done(wait_done)
  );

  always_comb begin
    unique case (key_index)
      3'h0: key_addr = `NVSC_KEY0;
      3'h1: key_addr = `NVSC_KEY1;
      3'h2: key_addr = `NVSC_KEY2;
      3'h3: key_addr = `NVSC_KEY3;
      3'h4: key_addr = `NVSC_KEY4;
      // sixth key picks store or recall
      default: key_addr = (cmd == nvsc_pkg::nvsc_cmd_store) ? `NVSC_KEY_STORE
                                                              : `NVSC_KEY_RECALL;
    endcase
  end

  // timer loads on entry to every timed phase
  always_comb begin
    wait_load = 1'b0;
    wait_count = ACCESS_CNT;
    unique case (state)
      st_power: begin
        wait_load = !supply_seen && supply_good;
        wait_count = CW'(RESTORE_CLKS);
      end
      st_idle: begin
        wait_load = req_valid && !(req.cmd == nvsc_pkg::nvsc_cmd_store && !supply_good);
      end
      st_access: begin
        wait_load = wait_done;
        wait_count = ACCESS_CNT;
      end
      st_gap: begin
        wait_load = wait_done && key_index == 3'h5;
        wait_count = (cmd == nvsc_pkg::nvsc_cmd_store) ? CW'(STORE_CLKS) : CW'(RECALL_CLKS);
      end
      st_key: begin
        wait_load = 1'b1;
      end
      st_busy: begin
        wait_load = 1'b0;
      end
    endcase
  end

  // sequencing of phases
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= st_power;
      supply_seen <= 1'b0;
      cmd <= nvsc_pkg::nvsc_cmd_read;
      key_index <= 3'h0;
    end else begin
      unique case (state)
        // wait for restore after supply good
        st_power: begin
          if (!supply_seen && supply_good) begin
            supply_seen <= 1'b1;
          end else if (supply_seen && wait_done) begin
            state <= st_idle;
          end
        end
        st_idle: begin
          key_index <= 3'h0;
          if (req_valid && !(req.cmd == nvsc_pkg::nvsc_cmd_store && !supply_good)) begin
            cmd <= req.cmd;
            state <= st_access;
          end
        end
        st_access: begin
          if (wait_done) begin
            state <= st_gap;
          end
        end
        st_gap: begin
          if (wait_done) begin
            if (cmd == nvsc_pkg::nvsc_cmd_store || cmd == nvsc_pkg::nvsc_cmd_recall) begin
              // keys issued in order, a timed gap with select high between each
              if (key_index == 3'h5) begin
                state <= st_busy;
              end else begin
                key_index <= key_index + 3'h1;
                state <= st_key;
              end
            end else begin
              state <= st_idle;
            end
          end
        end
        st_key: begin
          state <= st_access;
        end
        // host idles through store or recall
        st_busy: begin
          if (wait_done) begin
            state <= st_idle;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // bus pins: select framed per access so each key is its own read
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      bus.chip_select_n <= 1'b1;
      bus.output_enable_n <= 1'b1;
      bus.write_strobe_n <= 1'b1;
      bus.byte_address <= 15'h0000;
      shared_data_lines_out <= 8'h00;
      shared_data_lines_oe_n <= 1'b1;
    end else begin
      bus.chip_select_n <= !(state == st_access && !wait_done);
      // keys use output enable high, high during writes too
      bus.output_enable_n <= !(state == st_access && !wait_done &&
                               cmd == nvsc_pkg::nvsc_cmd_read);
      // strobe low only for write; high for keys
      bus.write_strobe_n <= !(state == st_access && !wait_done &&
                              cmd == nvsc_pkg::nvsc_cmd_write);
      // address settles a cycle before select falls
      if (state == st_idle && req_valid) begin
        // full address for plain accesses, first key otherwise
        if (req.cmd == nvsc_pkg::nvsc_cmd_read || req.cmd == nvsc_pkg::nvsc_cmd_write) begin
          bus.byte_address <= req.addr;
        end else begin
          bus.byte_address <= {1'b0, `NVSC_KEY0};
        end
        shared_data_lines_out <= req.data;
      end else if (state == st_key || (state == st_access && wait_load == 1'b0 &&
                   cmd != nvsc_pkg::nvsc_cmd_read && cmd != nvsc_pkg::nvsc_cmd_write)) begin
        // key address in low 14 bits
        bus.byte_address <= {1'b0, key_addr};
      end
      // data driven until strobe has risen
      shared_data_lines_oe_n <= !(state == st_access && cmd == nvsc_pkg::nvsc_cmd_write);
    end
  end

  // response path
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      store_refused <= 1'b0;
      req_ready <= 1'b0;
    end else begin
      // sample the byte at end of the read
      rsp_valid <= state == st_access && wait_done && cmd == nvsc_pkg::nvsc_cmd_read;
      if (state == st_access && wait_done && cmd == nvsc_pkg::nvsc_cmd_read) begin
        rsp_data <= shared_data_lines_in;
      end
      store_refused <= state == st_idle && req_valid &&
                       req.cmd == nvsc_pkg::nvsc_cmd_store && !supply_good;
      // no request taken until power-up recall done
      req_ready <= (state == st_gap && wait_done && key_index != 3'h5 &&
                    (cmd == nvsc_pkg::nvsc_cmd_read || cmd == nvsc_pkg::nvsc_cmd_write)) ||
                   (state == st_busy && wait_done) ||
                   (state == st_power && supply_seen && wait_done) ||
                   (state == st_idle && !req_valid);
    end
  end

  // address never changes while write strobe low
  addr_write_stable_a: assert property (@(posedge core_clk) disable iff (reset)
    !bus.write_strobe_n && !$past(bus.write_strobe_n) |-> $stable(bus.byte_address))
    else $error("address moved during write");
  // output enable high whenever strobe low
  oe_during_write_a: assert property (@(posedge core_clk) disable iff (reset)
    !bus.write_strobe_n |-> bus.output_enable_n)
    else $error("output enable low in write");
  powerup_idle_a: assert property (@(posedge core_clk) disable iff (reset)
    $past(state) == st_power |-> bus.chip_select_n && bus.write_strobe_n)
    else $error("bus active during power-up");
  key_strobe_high_a: assert property (@(posedge core_clk) disable iff (reset)
    (cmd == nvsc_pkg::nvsc_cmd_store || cmd == nvsc_pkg::nvsc_cmd_recall) &&
    state != st_idle |-> bus.write_strobe_n)
    else $error("strobe low during key");
  // store keys are reads with output enable high
  key_oe_high_a: assert property (@(posedge core_clk) disable iff (reset)
    !bus.chip_select_n && cmd == nvsc_pkg::nvsc_cmd_store |-> bus.output_enable_n)
    else $error("output enable low on key");
  // recall key addresses carry a zero top bit
  key_top_bit_a: assert property (@(posedge core_clk) disable iff (reset)
    !bus.chip_select_n && cmd == nvsc_pkg::nvsc_cmd_recall |-> !bus.byte_address[14])
    else $error("key top address bit set");
  store_refuse_a: assert property (@(posedge core_clk) disable iff (reset)
    state == st_idle && req_valid && req.cmd == nvsc_pkg::nvsc_cmd_store && !supply_good
    |=> store_refused && state == st_idle)
    else $error("store not refused");
  busy_quiet_a: assert property (@(posedge core_clk) disable iff (reset)
    state == st_busy && $past(state) == st_busy |-> bus.chip_select_n)
    else $error("access during busy period");
  // each access is one select pulse of nine cycles
  // pulse length tied to the 45 ns cycle at 5 ns clock
  sequence select_low_run;
    !bus.chip_select_n [*8] ##1 !bus.chip_select_n;
  endsequence
  sequence select_release;
    bus.chip_select_n;
  endsequence
  select_frame_a: assert property (@(posedge core_clk) disable iff (reset)
    $fell(bus.chip_select_n) |-> select_low_run ##1 select_release)
    else $error("select pulse wrong length");
endmodule
`default_nettype wire

// ### nvsc_map.svh
// timing counts and key addresses for the shadow-memory host controller
`ifndef NVSC_MAP_SVH
`define NVSC_MAP_SVH
`define NVSC_CLK_PERIOD_NS 5
`define NVSC_CYCLE_NS 45
`define NVSC_CYCLE_CLKS ((`NVSC_CYCLE_NS + `NVSC_CLK_PERIOD_NS - 1) / `NVSC_CLK_PERIOD_NS)
`define NVSC_STORE_DURATION_MS 10
`define NVSC_STORE_CLKS (`NVSC_STORE_DURATION_MS * 1000000 / `NVSC_CLK_PERIOD_NS)
`define NVSC_RECALL_DURATION_US 20
`define NVSC_RECALL_CLKS (`NVSC_RECALL_DURATION_US * 1000 / `NVSC_CLK_PERIOD_NS)
`define NVSC_RESTORE_DURATION_US 550
`define NVSC_RESTORE_CLKS (`NVSC_RESTORE_DURATION_US * 1000 / `NVSC_CLK_PERIOD_NS)
`define NVSC_KEY0 14'h0e38
`define NVSC_KEY1 14'h31c7
`define NVSC_KEY2 14'h03e0
`define NVSC_KEY3 14'h3c1f
`define NVSC_KEY4 14'h303f
`define NVSC_KEY_STORE 14'h0fc0
`define NVSC_KEY_RECALL 14'h0c63
`endif

// ### nvsc_pkg.sv
// types for the shadow-memory host controller
package nvsc_pkg;
  typedef enum logic [2:0] {
    nvsc_cmd_read = 3'h0,
    nvsc_cmd_write = 3'h1,
    nvsc_cmd_store = 3'h2,
    nvsc_cmd_recall = 3'h3
  } nvsc_cmd_type;
  typedef struct packed {
    nvsc_cmd_type cmd;
    logic [14:0] addr;
    logic [7:0] data;
  } nvsc_req_type;
  typedef struct packed {
    logic chip_select_n;
    logic output_enable_n;
    logic write_strobe_n;
    logic [14:0] byte_address;
  } nvsc_bus_type;
endpackage

// ### nvsc_wait.sv
// down counter that times a bus phase or a nonvolatile busy period
`timescale 1ns/10ps
`default_nettype none
module nvsc_wait #(
  parameter int WIDTH = 24
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  output logic done
);
  logic [WIDTH-1:0] remain;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      remain <= '0;
    end else if (load) begin
      remain <= count;
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end
  end
  // done must not look at load: callers derive load from done
  assign done = (remain == '0);
endmodule
`default_nettype wire

// ### test_nv_shadow_sram_store_recall.sv
// self-checking bench for the shadow-memory host controller
`timescale 1ns/10ps
`default_nettype none
module test_nv_shadow_sram_store_recall;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  logic supply_good = 1'b0;
  nvsc_pkg::nvsc_req_type req = '0;
  logic req_ready, rsp_valid, store_refused, oe_n;
  logic [7:0] rsp_data, dq_out, dq_line;
  nvsc_pkg::nvsc_bus_type bus;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  always #2.5 core_clk = ~core_clk;
  nvsc_host #(.STORE_CLKS(20), .RECALL_CLKS(20), .RESTORE_CLKS(20)) i_nvsc_host (
    .core_clk(core_clk), .reset(reset), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .store_refused(store_refused), .supply_good(supply_good), .bus(bus),
    .shared_data_lines_in(dq_line), .shared_data_lines_out(dq_out),
    .shared_data_lines_oe_n(oe_n));
  nvsc_dev_model i_nvsc_dev_model (.core_clk(core_clk), .supply_good(supply_good),
    .bus(bus), .host_out(dq_out), .host_oe_n(oe_n), .line(dq_line));
  task automatic close_out;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t flag %b want %b", $time, got, exp);
    end
  endtask
  task automatic issue(input nvsc_pkg::nvsc_cmd_type c, input logic [14:0] a, input logic [7:0] d);
    req <= '{c, a, d};
    req_valid <= 1'b1;
    do @(posedge core_clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
  endtask
  // ready may lag the take by a cycle
  task automatic idle;
    repeat (2) @(posedge core_clk);
    while (req_ready !== 1'b1) @(posedge core_clk);
  endtask
  task automatic await(input bit refusal);
    int n;
    n = 0;
    while ((refusal ? store_refused : rsp_valid) !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 50) begin
      failures++;
      $display("BAD %0t no response", $time);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    issue(nvsc_pkg::nvsc_cmd_write, a, d);
    idle();
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] exp);
    issue(nvsc_pkg::nvsc_cmd_read, a, 8'h00);
    await(1'b0);
    chk(rsp_data, exp);
    idle();
  endtask
  task automatic nv(input nvsc_pkg::nvsc_cmd_type c);
    issue(c, 15'h0000, 8'h00);
    idle();
  endtask
  task automatic t_rw;
    wr(15'h0000, 8'h3c);
    wr(15'h7fff, 8'hc3);
    wr(15'h4e38, 8'h81);
    wr(15'h0e38, 8'h18);
    rd(15'h0000, 8'h3c);
    rd(15'h7fff, 8'hc3);
    rd(15'h4e38, 8'h81);
    rd(15'h0e38, 8'h18);
    $display("test rw done");
  endtask
  task automatic t_nv;
    wr(15'h0123, 8'h5a);
    nv(nvsc_pkg::nvsc_cmd_store);
    wr(15'h0123, 8'ha5);
    rd(15'h0123, 8'ha5);
    nv(nvsc_pkg::nvsc_cmd_recall);
    rd(15'h0123, 8'h5a);
    rd(15'h7fff, 8'hc3);
    wr(15'h0123, 8'h77);
    nv(nvsc_pkg::nvsc_cmd_recall);
    rd(15'h0123, 8'h5a);
    $display("test store recall done");
  endtask
  // low supply: store dropped, shadow keeps the older byte
  task automatic t_low;
    wr(15'h0123, 8'h33);
    supply_good <= 1'b0;
    issue(nvsc_pkg::nvsc_cmd_store, 15'h0000, 8'h00);
    await(1'b1);
    chk_flag(store_refused, 1'b1);
    idle();
    supply_good <= 1'b1;
    repeat (40) @(posedge core_clk);
    idle();
    rd(15'h0123, 8'h5a);
    $display("test low supply done");
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    repeat (3) @(posedge core_clk);
    supply_good <= 1'b1;
    idle();
    t_rw();
    t_nv();
    t_low();
    close_out();
  end
endmodule
`default_nettype wire
